// ===== logic/upi_pkg.sv
/*
 * Constants and carrier types for the USB power control and interrupt enable register bank.
 * Assumes a single 25 MHz system clock and an APB register bus with 32-bit data.
 */
package upi_pkg;

    // Register byte addresses; the power control and interrupt enable registers have clear, set and invert companions.
    localparam logic [7:0] POWER_CONTROL_ADDR    = 8'h00;
    localparam logic [7:0] INTERRUPT_ENABLE_ADDR = 8'h10;
    localparam logic [7:0] MODE_STATUS_ADDR      = 8'h20;
    localparam logic [7:0] FLAG_STATUS_ADDR      = 8'h30;
    localparam logic [1:0] SUB_WRITE             = 2'h0;
    localparam logic [1:0] SUB_CLEAR             = 2'h1;
    localparam logic [1:0] SUB_SET               = 2'h2;
    localparam logic [1:0] SUB_INVERT            = 2'h3;

    // Field positions in the power control register.
    localparam int OPERATION_ENABLE_BIT = 0;
    localparam int SUSPEND_REQUEST_BIT  = 1;
    localparam int MODULE_BUSY_BIT      = 3;
    localparam int SLEEP_GUARD_BIT      = 4;
    localparam int ACTIVITY_PENDING_BIT = 7;

    // Writable bits of each register; everything else reads as zero except power bits 3 (busy) and 7 (activity pending).
    localparam logic [7:0] POWER_WRITE_MASK  = 8'h13;
    localparam logic [7:0] ENABLE_WRITE_MASK = 8'hFF;
    localparam logic [7:0] POWER_RESET       = 8'h00;
    localparam logic [7:0] ENABLE_RESET      = 8'h00;

    // Cycles that the module stays busy after being disabled, before it may be enabled again.
    localparam int SHUTDOWN_TIME_NS = 400;
    localparam int CLOCK_PERIOD_NS  = 40;
    localparam logic [3:0] SHUTDOWN_CYCLES = 4'((SHUTDOWN_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

    typedef enum logic [1:0] {
        UPI_OFF,
        UPI_ON,
        UPI_SHUTDOWN
    } upi_power_e;

    // Pending interrupt flags from the USB core, in enable-bit order.
    typedef struct packed {
        logic stall;
        logic attach;
        logic resume;
        logic idle;
        logic token_done;
        logic start_of_frame;
        logic error;
        logic reset_or_detach;
    } upi_flags_s;

endpackage

// ===== logic/upi_regs.sv
/*
 * USB power control and interrupt enable register bank with APB slave.
 * Assumes APB master timing, synchronous flag and activity inputs, and a core that reports idle.
 */
// Behaviour
// R1: Power and enable registers read zero in bits 31-8; power bits 6, 5, 2 zero.
// R2: Activity pending bit 7 reads one while activity seen but interrupt not raised.
// R3: Sleep guard set blocks sleep during activity or pending notification.
// R4: Busy bit 3 is one while active or not yet ready to enable.
// R5: Suspend bit 1 gates the 48 MHz clock and idles the transceiver.
// R6: Operation enable bit 0 turns the module on or off.
// R7: Disabled module holds outputs inactive, frees pins, powers down analog.
// R8: Software must not trust or write other registers while disabled and busy.
// R9: Enable bit 7 gates the stall handshake interrupt.
// R10: Enable bit 6 gates the attach interrupt.
// R11: Enable bit 5 gates the resume interrupt.
// R12: Enable bit 4 gates the idle detect interrupt.
// R13: Enable bit 3 gates the token done interrupt.
// R14: Enable bit 2 gates the start of frame interrupt.
// R15: Enable bit 1 gates the error interrupt.
// R16: In device mode enable bit 0 gates the bus reset flag.
// R17: In host mode enable bit 0 gates the detach flag.
// R18: Error conditions raise the module flag only with error enable set.
// R19: Clear, set and invert companions at offsets 0x4, 0x8, 0xC.
// R20: Module interrupt request is raised whenever any enabled flag is set while the module is on.
module upi_regs (
    input  wire logic              CLOCK,
    input  wire logic              RESET_N,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic                   PREADY,
    output logic [31:0]            PRDATA,
    output logic                   PSLVERR,
    input  wire upi_pkg::upi_flags_s FLAGS,
    input  wire logic              HOST_MODE,
    input  wire logic              BUS_ACTIVITY,
    input  wire logic              CORE_IDLE,
    input  wire logic              SLEEP_REQUEST,
    output logic                   MODULE_INTERRUPT_FLAG,
    output logic                   USB_CLOCK_ENABLE,
    output logic                   TRANSCEIVER_LOW_POWER,
    output logic                   MODULE_ON,
    output logic                   PINS_OWNED,
    output logic                   ANALOG_ENABLE,
    output logic                   SLEEP_BLOCK
);

    logic [7:0]          power_control;
    logic [7:0]          interrupt_enable;
    logic                activity_pending;
    logic [3:0]          shutdown_count;
    upi_pkg::upi_power_e power_state;
    upi_pkg::upi_power_e next_power_state;
    logic [7:0]          enabled_flags;
    logic                bus_write;
    logic                bus_read;
    logic                module_busy;
    logic [31:0]         next_read_data;
    logic                addr_valid;
    logic                state_on;
    logic [3:0]          busy_age;

    default clocking bank_clk @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    function automatic logic [7:0] apply_write(input logic [7:0] value, input logic [1:0] sub,
                                               input logic [7:0] data, input logic [7:0] mask);
        logic [7:0] result;
        result = value;
        case (sub)
            upi_pkg::SUB_WRITE:  result = data;
            upi_pkg::SUB_CLEAR:  result = value & ~data;
            upi_pkg::SUB_SET:    result = value | data;
            upi_pkg::SUB_INVERT: result = value ^ data;
            default:             result = value;
        endcase
        return (result & mask) | (value & ~mask);
    endfunction

    // One wait state; a write lands only at the edge where the master sees PREADY high.
    assign bus_write  = PSEL && PENABLE && PWRITE && PREADY;
    assign bus_read   = PSEL && PENABLE && !PWRITE && !PREADY;
    assign addr_valid = (PADDR[1:0] == 2'h0) && (PADDR[7:6] == 2'h0);

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !addr_valid;
        end
    end

    // R6: enable and suspend
    // R19: companion write decode
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            power_control <= upi_pkg::POWER_RESET;
        end else if (bus_write && addr_valid && PADDR[7:4] == upi_pkg::POWER_CONTROL_ADDR[7:4]) begin
            power_control <= apply_write(power_control, PADDR[3:2], PWDATA[7:0], upi_pkg::POWER_WRITE_MASK);
        end
    end

    // R19: enable register companions
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            interrupt_enable <= upi_pkg::ENABLE_RESET;
        end else if (bus_write && addr_valid && PADDR[7:4] == upi_pkg::INTERRUPT_ENABLE_ADDR[7:4]) begin
            interrupt_enable <= apply_write(interrupt_enable, PADDR[3:2], PWDATA[7:0],
                                            upi_pkg::ENABLE_WRITE_MASK);
        end
    end

    // R4: power sequencing drives busy
    always_comb begin
        next_power_state = power_state;
        case (power_state)
            upi_pkg::UPI_OFF: begin
                if (power_control[upi_pkg::OPERATION_ENABLE_BIT]) begin
                    next_power_state = upi_pkg::UPI_ON;
                end
            end
            upi_pkg::UPI_ON: begin
                if (!power_control[upi_pkg::OPERATION_ENABLE_BIT]) begin
                    next_power_state = upi_pkg::UPI_SHUTDOWN;
                end
            end
            upi_pkg::UPI_SHUTDOWN: begin
                if (shutdown_count == 4'h0 && CORE_IDLE) begin
                    next_power_state = upi_pkg::UPI_OFF;
                end
            end
            default: next_power_state = upi_pkg::UPI_OFF;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            power_state    <= upi_pkg::UPI_OFF;
            shutdown_count <= 4'h0;
        end else begin
            power_state <= next_power_state;
            if (power_state == upi_pkg::UPI_ON && next_power_state == upi_pkg::UPI_SHUTDOWN) begin
                shutdown_count <= upi_pkg::SHUTDOWN_CYCLES;
            end else if (shutdown_count != 4'h0) begin
                shutdown_count <= shutdown_count - 4'h1;
            end
        end
    end

    assign module_busy = (power_state != upi_pkg::UPI_OFF);
    assign state_on    = (power_state == upi_pkg::UPI_ON);

    // R4: busy floor count
    // Age in the shutdown state; a small counter is cheaper for the checker than a long repetition.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            busy_age <= 4'h0;
        end else if (power_state != upi_pkg::UPI_SHUTDOWN) begin
            busy_age <= 4'h0;
        end else if (busy_age != 4'hF) begin
            busy_age <= busy_age + 4'h1;
        end
    end

    // R9: enable masks flags
    // R10: attach enable mask
    // R11: resume enable mask
    // R12: idle enable mask
    // R13: token done mask
    // R14: start of frame mask
    // R15: error enable mask
    // R16: bit 0 is bus reset in device mode
    // R17: bit 0 is detach in host mode
    // R18: error needs its enable
    assign enabled_flags = FLAGS & interrupt_enable;

    // R2: activity pending tracking
    // Set wins over the clear so that activity in the raise cycle is not lost.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            activity_pending <= 1'b0;
        end else if (power_state != upi_pkg::UPI_ON) begin
            activity_pending <= 1'b0;
        end else if (BUS_ACTIVITY) begin
            activity_pending <= 1'b1;
        end else if (MODULE_INTERRUPT_FLAG) begin
            activity_pending <= 1'b0;
        end
    end

    // R7: outputs inactive while disabled
    // R5: suspend gates clock
    // R20: module interrupt request
    // R3: sleep guard
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            MODULE_INTERRUPT_FLAG <= 1'b0;
            USB_CLOCK_ENABLE      <= 1'b0;
            TRANSCEIVER_LOW_POWER <= 1'b1;
            MODULE_ON             <= 1'b0;
            PINS_OWNED            <= 1'b0;
            ANALOG_ENABLE         <= 1'b0;
            SLEEP_BLOCK           <= 1'b0;
        end else begin
            MODULE_INTERRUPT_FLAG <= (power_state == upi_pkg::UPI_ON) && (|enabled_flags);
            USB_CLOCK_ENABLE      <= module_busy && !power_control[upi_pkg::SUSPEND_REQUEST_BIT];
            TRANSCEIVER_LOW_POWER <= !module_busy || power_control[upi_pkg::SUSPEND_REQUEST_BIT];
            MODULE_ON             <= (power_state == upi_pkg::UPI_ON);
            PINS_OWNED            <= (power_state == upi_pkg::UPI_ON);
            ANALOG_ENABLE         <= module_busy;
            SLEEP_BLOCK           <= SLEEP_REQUEST && power_control[upi_pkg::SLEEP_GUARD_BIT]
                                     && (BUS_ACTIVITY || activity_pending);
        end
    end

    // R1: unimplemented bits read zero
    // R8: status left readable while busy; software avoids relying on it
    always_comb begin
        next_read_data = 32'h0000_0000;
        case (PADDR[7:4])
            upi_pkg::POWER_CONTROL_ADDR[7:4]: begin
                next_read_data[7:0] = power_control & upi_pkg::POWER_WRITE_MASK;
                next_read_data[upi_pkg::MODULE_BUSY_BIT] = module_busy;
                next_read_data[upi_pkg::ACTIVITY_PENDING_BIT] = activity_pending;
            end
            upi_pkg::INTERRUPT_ENABLE_ADDR[7:4]: next_read_data[7:0] = interrupt_enable;
            upi_pkg::MODE_STATUS_ADDR[7:4]:      next_read_data[1:0] = {power_state == upi_pkg::UPI_ON, HOST_MODE};
            upi_pkg::FLAG_STATUS_ADDR[7:4]:      next_read_data[7:0] = enabled_flags;
            default:                             next_read_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (bus_read && addr_valid) begin
            PRDATA <= next_read_data;
        end else if (bus_read) begin
            PRDATA <= 32'h0000_0000;
        end
    end

    sequence shut_start_s;
        power_state == upi_pkg::UPI_ON && !power_control[upi_pkg::OPERATION_ENABLE_BIT];
    endsequence

    sequence busy_hold_s;
        module_busy [*8];
    endsequence

    irq_gate_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R20
        MODULE_INTERRUPT_FLAG |-> $past(|(FLAGS & interrupt_enable)))
        else $error("Interrupt raised without enabled flag.");
    error_mask_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R18
        (FLAGS.error && !interrupt_enable[1] && (FLAGS & interrupt_enable) == 8'h00) |=> !MODULE_INTERRUPT_FLAG)
        else $error("Masked error raised interrupt.");
    shutdown_busy_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R4
        shut_start_s |=> busy_hold_s)
        else $error("Busy dropped too soon after disable.");
    power_zero_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R1
        bus_read && PADDR == upi_pkg::POWER_CONTROL_ADDR |=> PRDATA[31:8] == 24'h0 && PRDATA[6:5] == 2'h0
        && !PRDATA[2])
        else $error("Reserved power bits read nonzero.");
    suspend_clock_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R5
        power_control[upi_pkg::SUSPEND_REQUEST_BIT] |=> !USB_CLOCK_ENABLE)
        else $error("USB clock ran in suspend.");
    off_outputs_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R7
        power_state == upi_pkg::UPI_OFF |=> !PINS_OWNED && !ANALOG_ENABLE)
        else $error("Disabled module drove outputs.");
    sleep_guard_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R3
        !power_control[upi_pkg::SLEEP_GUARD_BIT] |=> !SLEEP_BLOCK)
        else $error("Sleep blocked with guard clear.");
    set_write_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R19
        bus_write && PADDR == (upi_pkg::INTERRUPT_ENABLE_ADDR | 8'h08) |=> interrupt_enable ==
        ($past(interrupt_enable) | $past(PWDATA[7:0])))
        else $error("Set companion failed.");
    enable_on_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R6
        power_state == upi_pkg::UPI_OFF && power_control[0] |=> ##1 MODULE_ON)
        else $error("Module failed to turn on.");
    pending_set_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R2
        power_state == upi_pkg::UPI_ON && BUS_ACTIVITY |=> activity_pending)
        else $error("Activity pending not set.");

    // R6: turn on steps
    sequence on_request_s;
        power_state == upi_pkg::UPI_OFF && power_control[upi_pkg::OPERATION_ENABLE_BIT];
    endsequence

    sequence on_follow_s;
        state_on ##1 (MODULE_ON && PINS_OWNED && ANALOG_ENABLE);
    endsequence

    ready_pulse_a: assert property ( // R19
        PREADY |=> !PREADY)
        else $error("Ready held too long.");
    ready_wait_a: assert property ( // R19
        PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("Ready missing after wait.");
    error_ready_a: assert property ( // R19
        PSLVERR |-> PREADY)
        else $error("Error without ready.");

    bad_write_a: assert property ( // R19
        bus_write && !addr_valid |=> $stable(power_control) && $stable(interrupt_enable))
        else $error("Refused write changed a register.");
    enable_zero_a: assert property ( // R1
        bus_read && PADDR == upi_pkg::INTERRUPT_ENABLE_ADDR |=> PRDATA[31:8] == 24'h0)
        else $error("Reserved enable bits read nonzero.");

    suspend_xcvr_a: assert property ( // R5
        power_control[upi_pkg::SUSPEND_REQUEST_BIT] |=> TRANSCEIVER_LOW_POWER)
        else $error("Transceiver awake in suspend.");
    off_quiet_a: assert property ( // R7
        power_state == upi_pkg::UPI_OFF |=> !MODULE_ON && !USB_CLOCK_ENABLE && TRANSCEIVER_LOW_POWER
        && !MODULE_INTERRUPT_FLAG)
        else $error("Disabled module not quiet.");

    guard_block_a: assert property ( // R3
        SLEEP_REQUEST && power_control[upi_pkg::SLEEP_GUARD_BIT] && BUS_ACTIVITY |=> SLEEP_BLOCK)
        else $error("Sleep not blocked during activity.");
    pending_clear_a: assert property ( // R2
        state_on && !BUS_ACTIVITY && MODULE_INTERRUPT_FLAG |=> !activity_pending)
        else $error("Activity pending kept after interrupt.");

    idle_wait_a: assert property ( // R4
        power_state == upi_pkg::UPI_SHUTDOWN && !CORE_IDLE |=> module_busy)
        else $error("Busy dropped before core idle.");
    busy_floor_a: assert property ( // R4
        power_state == upi_pkg::UPI_SHUTDOWN && busy_age < upi_pkg::SHUTDOWN_CYCLES |=> module_busy)
        else $error("Busy shorter than shutdown time.");

    turn_on_a: assert property ( // R6
        on_request_s |=> on_follow_s)
        else $error("Enable did not turn module on.");
    turn_off_a: assert property ( // R6
        shut_start_s |=> power_state == upi_pkg::UPI_SHUTDOWN ##1 (!MODULE_ON && !PINS_OWNED))
        else $error("Disable did not release module.");

    stall_raise_a: assert property ( // R9
        state_on && FLAGS.stall && interrupt_enable[7] |=> MODULE_INTERRUPT_FLAG)
        else $error("Enabled stall flag raised nothing.");
    attach_raise_a: assert property ( // R10
        state_on && FLAGS.attach && interrupt_enable[6] |=> MODULE_INTERRUPT_FLAG)
        else $error("Enabled attach flag raised nothing.");
    resume_raise_a: assert property ( // R11
        state_on && FLAGS.resume && interrupt_enable[5] |=> MODULE_INTERRUPT_FLAG)
        else $error("Enabled resume flag raised nothing.");
    idle_raise_a: assert property ( // R12
        state_on && FLAGS.idle && interrupt_enable[4] |=> MODULE_INTERRUPT_FLAG)
        else $error("Enabled idle flag raised nothing.");
    token_raise_a: assert property ( // R13
        state_on && FLAGS.token_done && interrupt_enable[3] |=> MODULE_INTERRUPT_FLAG)
        else $error("Enabled token flag raised nothing.");
    frame_raise_a: assert property ( // R14
        state_on && FLAGS.start_of_frame && interrupt_enable[2] |=> MODULE_INTERRUPT_FLAG)
        else $error("Enabled frame flag raised nothing.");
    error_raise_a: assert property ( // R15
        state_on && FLAGS.error && interrupt_enable[1] |=> MODULE_INTERRUPT_FLAG)
        else $error("Enabled error flag raised nothing.");

    reset_raise_a: assert property ( // R16
        state_on && !HOST_MODE && FLAGS.reset_or_detach && interrupt_enable[0] |=> MODULE_INTERRUPT_FLAG)
        else $error("Enabled bus reset flag raised nothing.");
    detach_raise_a: assert property ( // R17
        state_on && HOST_MODE && FLAGS.reset_or_detach && interrupt_enable[0] |=> MODULE_INTERRUPT_FLAG)
        else $error("Enabled detach flag raised nothing.");

endmodule

// ===== tb/upi_core_model.sv
/*
 * Behavioural model of the USB core that sits behind the register bank.
 * Assumes the bench steers its flags and activity, and one clock.
 */
module upi_core_model #(
    parameter int IDLE_DELAY = 30
) (
    input  wire logic          clock,
    input  wire logic          reset_n,
    input  wire logic          module_on,
    input  wire logic [7:0]    flag_req,
    input  wire logic          act_req,
    output upi_pkg::upi_flags_s flags,
    output logic               bus_activity,
    output logic               core_idle
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // A switched-off core raises no flags and sees no traffic.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flags <= '0;
            bus_activity <= 1'b0;
        end else begin
            flags <= flag_req & {8{module_on}};
            bus_activity <= act_req & module_on;
        end
    end
    // The core winds down slowly, so busy must outlast the fixed shutdown time.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            core_idle <= 1'b1;
        end else if (module_on) begin
            cnt <= 0;
            core_idle <= 1'b0;
        end else if (cnt < IDLE_DELAY) begin
            cnt <= cnt + 1;
        end else begin
            core_idle <= 1'b1;
        end
    end
endmodule

// ===== tb/upi_regs_bench.sv
/*
 * Self-checking bench for the USB power control and interrupt enable bank.
 * Assumes the core model beside the design and the APB timing of the notes.
 */
module upi_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clock = 1'b0;
    logic                reset_n = 1'b0;
    logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]          paddr = 8'h00, flag_req = 8'h00, ie = 8'h00;
    logic [31:0]         pwdata = 32'h0, prdata, rdv, d;
    logic                pready, pslverr, erv, host_mode = 1'b0, act_req = 1'b0, sleep_req = 1'b0;
    logic                bus_act, core_idle, mif, clk_en, xcvr_lp, mod_on, pins, analog, sleep_blk;
    upi_pkg::upi_flags_s flags;
    int                  err_count = 0, check_count = 0, cycles = 0;

    always #20 clock = ~clock;

    upi_regs dut (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
        .FLAGS(flags), .HOST_MODE(host_mode), .BUS_ACTIVITY(bus_act), .CORE_IDLE(core_idle),
        .SLEEP_REQUEST(sleep_req), .MODULE_INTERRUPT_FLAG(mif), .USB_CLOCK_ENABLE(clk_en),
        .TRANSCEIVER_LOW_POWER(xcvr_lp), .MODULE_ON(mod_on), .PINS_OWNED(pins),
        .ANALOG_ENABLE(analog), .SLEEP_BLOCK(sleep_blk));
    upi_core_model #(.IDLE_DELAY(30)) core (.clock(clock), .reset_n(reset_n), .module_on(mod_on),
        .flag_req(flag_req), .act_req(act_req), .flags(flags), .bus_activity(bus_act),
        .core_idle(core_idle));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: output %b, expected %b", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    function automatic logic [7:0] upd(logic [7:0] o, logic [1:0] s, logic [7:0] v);
        case (s)
            upi_pkg::SUB_WRITE: return v;
            upi_pkg::SUB_CLEAR: return o & ~v;
            upi_pkg::SUB_SET:   return o | v;
            default:            return o ^ v;
        endcase
    endfunction

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            $display("ERROR %0t: timeout", $time);
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'h94003B61));
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, upi_pkg::POWER_CONTROL_ADDR, 32'h0);
        chk32(rdv, 32'h00000000);
        chk1(pins, 1'b0);
        chk1(xcvr_lp, 1'b1);
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            d = $urandom;
            apb(1'b1, upi_pkg::INTERRUPT_ENABLE_ADDR + 8'(4 * s), d);
            ie = upd(ie, 2'(s), d[7:0]);
            apb(1'b0, upi_pkg::INTERRUPT_ENABLE_ADDR, 32'h0);
            chk32(rdv, {24'h0, ie});
        end
        $display("test companions done");
        apb(1'b0, 8'h02, 32'h0);
        chk1(erv, 1'b1);
        chk32(rdv, 32'h0);
        apb(1'b1, 8'h44, 32'hFFFFFFFF);
        chk1(erv, 1'b1);
        $display("test refusal done");
        apb(1'b1, upi_pkg::POWER_CONTROL_ADDR, 32'hFFFFFFED);
        repeat (3) @(posedge clock);
        chk1(mod_on, 1'b1);
        chk1(pins, 1'b1);
        chk1(analog, 1'b1);
        apb(1'b0, upi_pkg::POWER_CONTROL_ADDR, 32'h0);
        chk32(rdv, 32'h00000009);
        apb(1'b1, upi_pkg::POWER_CONTROL_ADDR + 8'h08, 32'h2);
        apb(1'b0, upi_pkg::POWER_CONTROL_ADDR, 32'h0);
        chk32(rdv, 32'h0000000B);
        chk1(clk_en, 1'b0);
        chk1(xcvr_lp, 1'b1);
        apb(1'b1, upi_pkg::POWER_CONTROL_ADDR + 8'h0C, 32'h2);
        @(posedge clock);
        chk1(clk_en, 1'b1);
        chk1(xcvr_lp, 1'b0);
        $display("test power done");
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            d[i / 2] = i[0];
            d[8] = i[2];
            host_mode <= d[8];
            flag_req <= d[7:0];
            apb(1'b1, upi_pkg::INTERRUPT_ENABLE_ADDR, 32'h1 << (i / 2));
            repeat (3) @(posedge clock);
            chk1(mif, i[0]);
            apb(1'b0, upi_pkg::MODE_STATUS_ADDR, 32'h0);
            chk32(rdv, {30'h0, 1'b1, d[8]});
            apb(1'b0, upi_pkg::FLAG_STATUS_ADDR, 32'h0);
            chk32(rdv, {24'h0, d[7:0] & (8'h1 << (i / 2))});
        end
        $display("test interrupts done");
        flag_req <= 8'h02;
        apb(1'b1, upi_pkg::INTERRUPT_ENABLE_ADDR, 32'h0);
        act_req <= 1'b1;
        @(posedge clock);
        act_req <= 1'b0;
        repeat (3) @(posedge clock);
        apb(1'b0, upi_pkg::POWER_CONTROL_ADDR, 32'h0);
        chk32(rdv, 32'h00000089);
        chk1(mif, 1'b0);
        host_mode <= 1'b1;
        flag_req <= 8'h01;
        apb(1'b1, upi_pkg::INTERRUPT_ENABLE_ADDR, 32'h1);
        repeat (3) @(posedge clock);
        apb(1'b0, upi_pkg::POWER_CONTROL_ADDR, 32'h0);
        chk32(rdv, 32'h00000009);
        chk1(mif, 1'b1);
        flag_req <= 8'h00;
        $display("test activity done");
        sleep_req <= 1'b1;
        act_req <= 1'b1;
        apb(1'b1, upi_pkg::POWER_CONTROL_ADDR + 8'h08, 32'h10);
        repeat (2) @(posedge clock);
        chk1(sleep_blk, 1'b1);
        apb(1'b1, upi_pkg::POWER_CONTROL_ADDR + 8'h04, 32'h10);
        repeat (2) @(posedge clock);
        chk1(sleep_blk, 1'b0);
        act_req <= 1'b0;
        sleep_req <= 1'b0;
        $display("test guard done");
        apb(1'b1, upi_pkg::POWER_CONTROL_ADDR, 32'h0);
        apb(1'b0, upi_pkg::POWER_CONTROL_ADDR, 32'h0);
        chk32(rdv & 32'h7F, 32'h08);
        chk1(pins, 1'b0);
        repeat (12) @(posedge clock);
        apb(1'b0, upi_pkg::POWER_CONTROL_ADDR, 32'h0);
        chk32(rdv & 32'h7F, 32'h08);
        // only the power register is touched until busy clears.
        for (int n = 0; n < 20 && rdv[3] !== 1'b0; n++)
            apb(1'b0, upi_pkg::POWER_CONTROL_ADDR, 32'h0);
        chk32(rdv & 32'h7F, 32'h00);
        chk1(analog, 1'b0);
        chk1(xcvr_lp, 1'b1);
        $display("test disable done");
        finish_test();
    end
endmodule
